// ---- src/pec_top.sv ----
/*
  PWM generator enable and control: three edge-aligned generators, six
  compare outputs, load-ok reload, restart on commutation, write protect,
  software output control, fault protection and a reload/fault interrupt.
  Assumes synchronous register-port master on clk; pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module pec_top (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire pec_pkg::pec_req_s bus_req,
  output var  logic [7:0]       rdata,
  input  wire logic             global_load_ok,
  input  wire logic             commutation,
  input  wire logic             fault_in,
  output var  logic [5:0]       pwm_out,
  output var  logic             irq
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [11:0] val_addr(input int unsigned n);
    val_addr = pec_pkg::OFS_VAL_BASE + 12'(2 * n);
  endfunction : val_addr

  function automatic logic [11:0] gen_ofs(input int unsigned g, input int unsigned kind);
    logic [11:0] r;
    r = 12'h000;
    case (kind)
      0: r = (g == 0) ? pec_pkg::OFS_ENC_A : (g == 1) ? pec_pkg::OFS_ENC_B
                                                      : pec_pkg::OFS_ENC_C;
      1: r = (g == 0) ? pec_pkg::OFS_CNT_A : (g == 1) ? pec_pkg::OFS_CNT_B
                                                      : pec_pkg::OFS_CNT_C;
      default: r = (g == 0) ? pec_pkg::OFS_MOD_A : (g == 1) ? pec_pkg::OFS_MOD_B
                                                            : pec_pkg::OFS_MOD_C;
    endcase
    gen_ofs = r;
  endfunction : gen_ofs

  // Generator that times output k: its own pair's generator, or A
  function automatic int unsigned gen_of(input logic multi_timebase_select, input int unsigned k);
    gen_of = multi_timebase_select ? (k / 2) : 0;
  endfunction : gen_of

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [2:0]  gen_en_ff, gld_sel_ff, restart_ff, ldok_ff, rie_ff, en_dly_ff;
  logic        mtg_ff, wp_ff, fault_mask_ff, fault_ff;
  logic [5:0]  out_ctl_ff, out_val_ff, cinv_ff;
  logic [3:0]  irq_stat_ff;
  logic [15:0] cnt_ff     [3];
  logic [15:0] mod_buf_ff [3];
  logic [15:0] mod_act_ff [3];
  logic [15:0] val_buf_ff [6];
  logic [15:0] val_act_ff [6];
  logic [7:0]  fqc_ff [2];
  logic [15:0] dtm_ff [2];
  logic [7:0]  dmp_ff [2];
  logic [1:0]  gld_sync_ff, com_sync_ff, flt_sync_ff;
  logic        com_prev_ff;

  logic [2:0]  eff_en, cyc_start, half_edge, reload_ev, reload_ok;
  logic        com_rise;
  logic [11:0] a;
  logic        wr;

  assign a  = bus_req.addr;
  assign wr = bus_req.wr;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gld_sync_ff <= 2'h0;
      com_sync_ff <= 2'h0;
      flt_sync_ff <= 2'h0;
      com_prev_ff <= 1'b0;
    end else begin
      gld_sync_ff <= {gld_sync_ff[0], global_load_ok};
      com_sync_ff <= {com_sync_ff[0], commutation};
      flt_sync_ff <= {flt_sync_ff[0], fault_in};
      com_prev_ff <= com_sync_ff[1];
    end
  end

  assign com_rise = com_sync_ff[1] & ~com_prev_ff;

  // ----------------------------------------------------------------------
  // Generator timing
  // ----------------------------------------------------------------------
  // One clock serves core, system and bus roles, so no crossing is needed
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      eff_en[g]    = mtg_ff ? gen_en_ff[g] : gen_en_ff[0];
      cyc_start[g] = eff_en[g] & (~en_dly_ff[g] | (cnt_ff[g] == mod_act_ff[g])
                     | (restart_ff[g] & com_rise));
      half_edge[g] = cyc_start[g] | (eff_en[g] & (cnt_ff[g] == mod_act_ff[g]));
      reload_ev[g] = cyc_start[g];
      reload_ok[g] = reload_ev[g] & (gld_sel_ff[g] ? gld_sync_ff[1] : ldok_ff[g]);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_dly_ff <= 3'h0;
      for (int g = 0; g < 3; g++) begin
        cnt_ff[g]     <= pec_pkg::RST_WORD;
        mod_act_ff[g] <= pec_pkg::RST_MOD;
      end
    end else begin
      en_dly_ff <= eff_en;
      for (int g = 0; g < 3; g++) begin
        if (!eff_en[g] || cyc_start[g])
          cnt_ff[g] <= pec_pkg::RST_WORD;
        else
          cnt_ff[g] <= cnt_ff[g] + 16'h0001;
        if (reload_ok[g])
          mod_act_ff[g] <= mod_buf_ff[g];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < 6; k++)
        val_act_ff[k] <= pec_pkg::RST_WORD;
    end else begin
      for (int k = 0; k < 6; k++)
        if (reload_ok[gen_of(mtg_ff, k)])
          val_act_ff[k] <= val_buf_ff[k];
    end
  end

  // ----------------------------------------------------------------------
  // Fault latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      fault_ff <= 1'b0;
    else if (flt_sync_ff[1])
      fault_ff <= 1'b1;
    else if (!eff_en[0] || half_edge[0])
      fault_ff <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_out <= 6'h00;
    end else begin
      for (int k = 0; k < 6; k++) begin
        // Live polarity bit: a polarity write flips the output mid-cycle
        if (fault_ff)
          pwm_out[k] <= 1'b0;
        else if (out_ctl_ff[k])
          pwm_out[k] <= out_val_ff[k];
        else if (!eff_en[gen_of(mtg_ff, k)])
          pwm_out[k] <= 1'b0;
        else if (cinv_ff[k])
          pwm_out[k] <= cnt_ff[gen_of(mtg_ff, k)] > val_act_ff[k];
        else
          pwm_out[k] <= cnt_ff[gen_of(mtg_ff, k)] < val_act_ff[k];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gen_en_ff  <= 3'h0;
      gld_sel_ff <= 3'h0;
      restart_ff <= 3'h0;
      rie_ff     <= 3'h0;
    end else begin
      for (int g = 0; g < 3; g++) begin
        if (wr && a == gen_ofs(g, 0)) begin
          gen_en_ff[g] <= bus_req.wdata[pec_pkg::ENC_EN_BIT];
          rie_ff[g]    <= bus_req.wdata[pec_pkg::ENC_RIE_BIT];
          if (!wp_ff) begin
            gld_sel_ff[g] <= bus_req.wdata[pec_pkg::ENC_GLD_BIT];
            restart_ff[g] <= bus_req.wdata[pec_pkg::ENC_RST_BIT];
          end
        end
      end
      if (wr && a == pec_pkg::OFS_IRQ_MASK)
        rie_ff <= bus_req.wdata[2:0];
    end
  end

  // Local load-ok: software sets, a reload taken on local load-ok clears; a write wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      ldok_ff <= 3'h0;
    else
      for (int g = 0; g < 3; g++)
        if (wr && a == gen_ofs(g, 0))
          ldok_ff[g] <= bus_req.wdata[pec_pkg::ENC_LDOK_BIT];
        else if (reload_ok[g] && !gld_sel_ff[g])
          ldok_ff[g] <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mtg_ff        <= 1'b0;
      wp_ff         <= 1'b0;
      out_ctl_ff    <= 6'h00;
      out_val_ff    <= 6'h00;
      cinv_ff       <= 6'h00;
      fault_mask_ff <= 1'b0;
    end else begin
      if (wr && a == pec_pkg::OFS_CONFIG) begin
        mtg_ff <= bus_req.wdata[pec_pkg::CFG_MTG_BIT];
        // Write protect is set-only so a runaway write cannot unlock it
        wp_ff  <= wp_ff | bus_req.wdata[pec_pkg::CFG_WP_BIT];
      end
      if (wr && a == pec_pkg::OFS_OUT_CTL)
        out_ctl_ff <= bus_req.wdata[5:0];
      if (wr && a == pec_pkg::OFS_OUT_VAL)
        out_val_ff <= bus_req.wdata[5:0];
      if (wr && a == pec_pkg::OFS_CINV)
        cinv_ff <= bus_req.wdata[5:0];
      if (wr && a == pec_pkg::OFS_IRQ_MASK)
        fault_mask_ff <= bus_req.wdata[pec_pkg::IRQ_FAULT_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int g = 0; g < 3; g++)
        mod_buf_ff[g] <= pec_pkg::RST_MOD;
      for (int k = 0; k < 6; k++)
        val_buf_ff[k] <= pec_pkg::RST_WORD;
      for (int i = 0; i < 2; i++) begin
        fqc_ff[i] <= pec_pkg::RST_BYTE;
        dtm_ff[i] <= pec_pkg::RST_WORD;
        dmp_ff[i] <= pec_pkg::RST_BYTE;
      end
    end else if (wr) begin
      for (int g = 0; g < 3; g++) begin
        if (a == gen_ofs(g, 2))
          mod_buf_ff[g][15:8] <= bus_req.wdata;
        if (a == gen_ofs(g, 2) + 12'h001)
          mod_buf_ff[g][7:0] <= bus_req.wdata;
      end
      for (int k = 0; k < 6; k++) begin
        if (a == val_addr(k))
          val_buf_ff[k][15:8] <= bus_req.wdata;
        if (a == val_addr(k) + 12'h001)
          val_buf_ff[k][7:0] <= bus_req.wdata;
      end
      if (a == pec_pkg::OFS_FQC_B) fqc_ff[0] <= bus_req.wdata;
      if (a == pec_pkg::OFS_FQC_C) fqc_ff[1] <= bus_req.wdata;
      if (a == pec_pkg::OFS_DTM_B) dtm_ff[0][15:8] <= bus_req.wdata;
      if (a == pec_pkg::OFS_DTM_B + 12'h001) dtm_ff[0][7:0] <= bus_req.wdata;
      if (a == pec_pkg::OFS_DTM_C) dtm_ff[1][15:8] <= bus_req.wdata;
      if (a == pec_pkg::OFS_DTM_C + 12'h001) dtm_ff[1][7:0] <= bus_req.wdata;
      if (a == pec_pkg::OFS_DMP0) dmp_ff[0] <= bus_req.wdata;
      if (a == pec_pkg::OFS_DMP1) dmp_ff[1] <= bus_req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status: reload flags A-C and fault; write one to clear
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= 4'h0;
      irq         <= 1'b0;
    end else begin
      // A new event in the clearing cycle survives the clear
      irq_stat_ff <= (irq_stat_ff & ~((wr && a == pec_pkg::OFS_IRQ_STAT)
                      ? bus_req.wdata[3:0] : 4'h0)) | {flt_sync_ff[1], reload_ev};
      irq <= |(irq_stat_ff & {fault_mask_ff, rie_ff});
    end
  end

  // ----------------------------------------------------------------------
  // Register reads: data stand in the cycle after the strobe only
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= pec_pkg::RST_BYTE;
    end else begin
      rdata <= 8'h00;
      if (bus_req.rd) begin
        for (int g = 0; g < 3; g++) begin
          if (a == gen_ofs(g, 0))
            rdata <= {gen_en_ff[g], gld_sel_ff[g], 3'h0, restart_ff[g],
                      ldok_ff[g], rie_ff[g]};
          if (a == gen_ofs(g, 1))                 rdata <= cnt_ff[g][15:8];
          if (a == gen_ofs(g, 1) + 12'h001)       rdata <= cnt_ff[g][7:0];
          if (a == gen_ofs(g, 2))                 rdata <= mod_buf_ff[g][15:8];
          if (a == gen_ofs(g, 2) + 12'h001)       rdata <= mod_buf_ff[g][7:0];
        end
        for (int k = 0; k < 6; k++) begin
          if (a == val_addr(k))                   rdata <= val_buf_ff[k][15:8];
          if (a == val_addr(k) + 12'h001)         rdata <= val_buf_ff[k][7:0];
        end
        case (a)
          pec_pkg::OFS_CONFIG:   rdata <= {6'h00, wp_ff, mtg_ff};
          pec_pkg::OFS_OUT_CTL:  rdata <= {2'h0, out_ctl_ff};
          pec_pkg::OFS_OUT_VAL:  rdata <= {2'h0, out_val_ff};
          pec_pkg::OFS_READBACK: rdata <= {2'h0, pwm_out};
          pec_pkg::OFS_CINV:     rdata <= {2'h0, cinv_ff};
          pec_pkg::OFS_IRQ_STAT: rdata <= {4'h0, irq_stat_ff};
          pec_pkg::OFS_IRQ_MASK: rdata <= {4'h0, fault_mask_ff, rie_ff};
          pec_pkg::OFS_FQC_B:    rdata <= {fqc_ff[0][7:1], irq_stat_ff[1]};
          pec_pkg::OFS_FQC_C:    rdata <= {fqc_ff[1][7:1], irq_stat_ff[2]};
          pec_pkg::OFS_DTM_B:    rdata <= dtm_ff[0][15:8];
          pec_pkg::OFS_DTM_B + 12'h001: rdata <= dtm_ff[0][7:0];
          pec_pkg::OFS_DTM_C:    rdata <= dtm_ff[1][15:8];
          pec_pkg::OFS_DTM_C + 12'h001: rdata <= dtm_ff[1][7:0];
          pec_pkg::OFS_DMP0:     rdata <= dmp_ff[0];
          pec_pkg::OFS_DMP1:     rdata <= dmp_ff[1];
          default:               ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_commute_armed;
    restart_ff[0] && eff_en[0] && com_rise;
  endsequence

  property p_pol_low;
    (!fault_ff && !out_ctl_ff[0] && eff_en[0] && !cinv_ff[0]
      && cnt_ff[0] < val_act_ff[0]) |=> pwm_out[0];
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("out0 low below compare");

  property p_pol_high;
    (!fault_ff && !out_ctl_ff[1] && eff_en[0] && cinv_ff[1]
      && cnt_ff[0] <= val_act_ff[1]) |=> !pwm_out[1];
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("out1 high not above");

  property p_gang;
    !mtg_ff && !gen_en_ff[0] && !fault_ff
      |=> pwm_out[5:2] == $past(out_ctl_ff[5:2] & out_val_ff[5:2]);
  endproperty
  a_gang: assert property (p_gang) else $error("outputs 2-5 run with A off");

  property p_split;
    mtg_ff && gen_en_ff[1] && !gen_en_ff[0] |-> eff_en[1] && !eff_en[0];
  endproperty
  a_split: assert property (p_split) else $error("split timebase enables wrong");

  property p_idle_out;
    !eff_en[0] && !out_ctl_ff[0] |=> !pwm_out[0];
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("idle output active");

  property p_enable_start;
    $rose(eff_en[0]) |-> reload_ev[0] ##1 cnt_ff[0] == 16'h0000;
  endproperty
  a_enable_start: assert property (p_enable_start) else $error("no reload at enable");

  property p_act_hold;
    !reload_ok[0] |=> $stable(mod_act_ff[0]);
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("active modulus moved");

  property p_restart;
    s_commute_armed |=> cnt_ff[0] == 16'h0000 ##1 cnt_ff[0] == 16'h0001 || !eff_en[0]
      || cyc_start[0];
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on commutation");

  property p_protect;
    wp_ff && $past(wp_ff) |-> $stable(gld_sel_ff) && $stable(restart_ff);
  endproperty
  a_protect: assert property (p_protect) else $error("protected bits changed");

  property p_fault_out;
    fault_ff |=> pwm_out == 6'h00;
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("output live under fault");

  property p_recover;
    fault_ff && !flt_sync_ff[1] && eff_en[0] && !half_edge[0] |=> fault_ff;
  endproperty
  a_recover: assert property (p_recover) else $error("fault cleared mid half-cycle");

endmodule : pec_top

`default_nettype wire

// ---- src/pec_pkg.sv ----
/*
  Package for the PWM generator enable and control block: register offsets,
  field positions, reset values and the register-bus request carrier.
  Assumes an 8-bit register port with byte addresses and one clock.
*/
package pec_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned N_GEN  = 3;
  localparam int unsigned N_OUT  = 6;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses; 16-bit registers: high byte first)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_ENC_A     = 12'h020;
  localparam logic [11:0] OFS_CONFIG    = 12'h022;
  localparam logic [11:0] OFS_OUT_CTL   = 12'h023;
  localparam logic [11:0] OFS_OUT_VAL   = 12'h024;
  localparam logic [11:0] OFS_READBACK  = 12'h025;
  localparam logic [11:0] OFS_CINV      = 12'h026;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h027;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h028;
  localparam logic [11:0] OFS_CNT_A     = 12'h02A;
  localparam logic [11:0] OFS_MOD_A     = 12'h02C;
  localparam logic [11:0] OFS_VAL_BASE  = 12'h040;
  localparam logic [11:0] OFS_ENC_B     = 12'h528;
  localparam logic [11:0] OFS_FQC_B     = 12'h529;
  localparam logic [11:0] OFS_CNT_B     = 12'h52A;
  localparam logic [11:0] OFS_MOD_B     = 12'h52C;
  localparam logic [11:0] OFS_DTM_B     = 12'h52E;
  localparam logic [11:0] OFS_ENC_C     = 12'h530;
  localparam logic [11:0] OFS_FQC_C     = 12'h531;
  localparam logic [11:0] OFS_CNT_C     = 12'h532;
  localparam logic [11:0] OFS_MOD_C     = 12'h534;
  localparam logic [11:0] OFS_DTM_C     = 12'h536;
  localparam logic [11:0] OFS_DMP0      = 12'h538;
  localparam logic [11:0] OFS_DMP1      = 12'h539;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned ENC_EN_BIT    = 7;
  localparam int unsigned ENC_GLD_BIT   = 6;
  localparam int unsigned ENC_RST_BIT   = 2;
  localparam int unsigned ENC_LDOK_BIT  = 1;
  localparam int unsigned ENC_RIE_BIT   = 0;
  localparam int unsigned CFG_MTG_BIT   = 0;
  localparam int unsigned CFG_WP_BIT    = 1;
  localparam int unsigned IRQ_FAULT_BIT = 3;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_MOD  = 16'h00FF;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pec_req_s;

endpackage : pec_pkg

// ---- sim/pec_bridge_model.sv ----
/*
  Gate-driver stand-in for the motor bridge: flags a desaturation fault.
  Assumes the bench raises trip while a switch should appear shorted.
*/
`timescale 1ns/1ps
`default_nettype none

module pec_bridge_model (
  input  wire logic       clk,
  input  wire logic [5:0] pwm_out,
  input  wire logic       trip,
  output var  logic       fault_in
);
  // --------------------------------------------------------------------
  // Desaturation detect
  // --------------------------------------------------------------------
  // Needs a switch turned on to trip, then latches until trip drops,
  // so a fault that blanks the outputs does not clear itself
  initial fault_in = 1'b0;
  always @(posedge clk) begin
    fault_in <= trip & (fault_in | (|pwm_out));
  end
endmodule : pec_bridge_model
`default_nettype wire

// ---- sim/pec_top_test.sv ----
/*
  Self-checking bench for pec_top: register tasks and scenario sequence.
  Assumes the bridge model drives the fault pin; one 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pec_top_test;
  logic              clk;
  logic              reset_n;
  logic              gl_ok;
  logic              trip;
  logic              comm;
  logic              fault_in;
  logic              irq;
  logic [7:0]        rdata;
  logic [5:0]        pwm_out;
  pec_pkg::pec_req_s req;
  int                miscompares;
  int                n_compared;

  pec_top DUT (.clk(clk), .reset_n(reset_n), .bus_req(req), .rdata(rdata),
    .global_load_ok(gl_ok), .commutation(comm), .fault_in(fault_in),
    .pwm_out(pwm_out), .irq(irq));
  pec_bridge_model bridge (.clk(clk), .pwm_out(pwm_out), .trip(trip), .fault_in(fault_in));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check($sformatf("reg %h", a), exp, rdata & m);
  endtask : rd

  // Window lengths are whole periods, so the count is phase independent
  task automatic duty(input int k, input int len, input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (len) begin
      @(posedge clk);
      #1 n = n + 8'(pwm_out[k]);
    end
    check($sformatf("high count out%0d", k), exp, n);
  endtask : duty

  // Looks 1 ns past each edge so the output launched there has settled
  task automatic wait_out(input int k, input logic v);
    int i;
    #1;
    for (i = 0; i < 10 && pwm_out[k] !== v; i++) begin
      @(posedge clk);
      #1;
    end
    check($sformatf("out%0d level", k), 8'(v), 8'(pwm_out[k]));
    if (pwm_out[k] !== v) summarize();
  endtask : wait_out

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    reset_n = 1'b0;
    req = '0;
    gl_ok = 1'b0;
    trip = 1'b0;
    comm = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(pec_pkg::OFS_ENC_A, 8'hFF, 8'h00);
    rd(pec_pkg::OFS_MOD_A + 12'h001, 8'hFF, 8'hFF);
    rd(pec_pkg::OFS_CINV, 8'hFF, 8'h00);
    rd(12'h100, 8'hFF, 8'h00);
    $display("test reset done");
    wr(pec_pkg::OFS_MOD_A + 12'h001, 8'h09);
    wr(pec_pkg::OFS_VAL_BASE + 12'h001, 8'h04);
    wr(pec_pkg::OFS_CINV, 8'h06);
    wr(pec_pkg::OFS_ENC_A, 8'h82);
    repeat (300) @(posedge clk);
    duty(0, 10, 8'h04);
    duty(1, 10, 8'h09);
    duty(2, 10, 8'h09);
    wr(pec_pkg::OFS_CINV, 8'h07);
    duty(0, 10, 8'h05);
    $display("test polarity done");
    wr(pec_pkg::OFS_MOD_A + 12'h001, 8'h13);
    wr(pec_pkg::OFS_ENC_A, 8'hC2);
    rd(pec_pkg::OFS_ENC_A, 8'hC4, 8'hC0);
    repeat (60) @(posedge clk);
    duty(0, 20, 8'h0A);
    @(posedge clk);
    gl_ok <= 1'b1;
    repeat (60) @(posedge clk);
    duty(0, 20, 8'h0F);
    wr(pec_pkg::OFS_CONFIG, 8'h02);
    wr(pec_pkg::OFS_ENC_A, 8'h84);
    rd(pec_pkg::OFS_ENC_A, 8'hC4, 8'hC0);
    wr(pec_pkg::OFS_CONFIG, 8'h03);
    repeat (3) @(posedge clk);
    duty(2, 20, 8'h00);
    duty(1, 20, 8'h13);
    $display("test load and protect done");
    wr(pec_pkg::OFS_ENC_A, 8'h00);
    repeat (3) @(posedge clk);
    duty(0, 20, 8'h00);
    wr(pec_pkg::OFS_ENC_B, 8'h80);
    wait_out(2, 1'b1);
    wr(pec_pkg::OFS_OUT_CTL, 8'h01);
    wr(pec_pkg::OFS_OUT_VAL, 8'h01);
    wait_out(0, 1'b1);
    wr(pec_pkg::OFS_IRQ_MASK, 8'h08);
    trip <= 1'b1;
    wait_out(0, 1'b0);
    rd(pec_pkg::OFS_IRQ_STAT, 8'h08, 8'h08);
    check("irq", 8'h01, 8'(irq));
    trip <= 1'b0;
    wait_out(0, 1'b1);
    wr(pec_pkg::OFS_IRQ_STAT, 8'h08);
    rd(pec_pkg::OFS_IRQ_STAT, 8'h08, 8'h00);
    check("irq", 8'h00, 8'(irq));
    $display("test fault and software control done");
    // Second reset clears write protect so restart can be armed
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(pec_pkg::OFS_CONFIG, 8'hFF, 8'h00);
    wr(pec_pkg::OFS_ENC_A, 8'h86);
    repeat (100) @(posedge clk);
    comm <= 1'b1;
    repeat (3) @(posedge clk);
    comm <= 1'b0;
    rd(pec_pkg::OFS_CNT_A + 12'h001, 8'hFF, 8'h01);
    wr(pec_pkg::OFS_OUT_CTL, 8'h01);
    wr(pec_pkg::OFS_OUT_VAL, 8'h01);
    wait_out(0, 1'b1);
    trip <= 1'b1;
    wait_out(0, 1'b0);
    trip <= 1'b0;
    // Counter is far from the modulus here, so only a restart ends the fault
    repeat (10) @(posedge clk);
    #1 check("out0 held", 8'h00, 8'(pwm_out[0]));
    @(posedge clk);
    comm <= 1'b1;
    repeat (3) @(posedge clk);
    comm <= 1'b0;
    wait_out(0, 1'b1);
    $display("test restart and engaged recovery done");
    summarize();
  end
endmodule : pec_top_test
`default_nettype wire
